// ==== core/wdg_control.sv ====
// Watchdog control: clock choice, protected control register, arm keys, expiry
//
// The APB slave port was decided locally.
`timescale 1ns/100ps

// Operation
// - Counter clock from aux, reference or oscillator
// - Select-1 clear: runs in stop only in pseudo stop with oscillator selected and enabled
// - Select-1 set: keeps counting in stop
// - Control loaded from flash after reset
// - Debug-stop: free in special, set-only normally
// - Window/rate update only unmasked, once normally
// - Zero writes ignored but use the chance
// - Nonzero flash rate starts a period
// - Clock-select change, or oscillator loss while oscillator selected, restarts
// - Normal-mode restart events on control writes
// - Special mode: every control write restarts
// - Window mode: arm early causes reset
// - First key repeatable, second key restarts
// - Debug-stop freezes counters during debug
// - Mask bit blocks update, keeps the chance
// - Rate selects length; expiry raises reset
// - Special debug override: longest, no window
// - Slow clock rate exponents table
// - Fast clock halved aux, exponents table
// - Wrong arm value causes reset
// - Arm writes ignored while disabled
module wdg_control #(
	parameter logic [4:0] EXP_SHRINK = 5'h00
) (
	input  wire logic                      clock_i,
	input  wire logic                      reset_n_i,
	input  wire logic                      psel_i,
	input  wire logic                      penable_i,
	input  wire logic                      pwrite_i,
	input  wire logic [wdg_pkg::WDG_AW-1:0] paddr_i,
	input  wire logic [31:0]               pwdata_i,
	output logic      [31:0]               prdata_o,
	output logic                           pready_o,
	output logic                           pslverr_o,
	input  wire logic                      aux_clock_i,
	input  wire logic                      internal_reference_clock_i,
	input  wire logic                      oscillator_clock_i,
	input  wire logic                      oscillator_ok_status_i,
	input  wire logic                      special_mode_i,
	input  wire logic                      stop_mode_i,
	input  wire logic                      pseudo_stop_select_i,
	input  wire logic                      osc_in_stop_enable_i,
	input  wire logic                      background_debug_i,
	input  wire logic [7:0]                flash_config_i,
	output logic                           watchdog_reset_o,
	output logic                           counters_frozen_o
);
	import wdg_pkg::*;

	// ------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n;
	logic aux_rise, irc_rise, osc_rise;
	logic osc_ok_s;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	wdg_sync_edge u_aux (.clock_i(clock_i), .reset_n_i(rst_n),
		.pin_i(aux_clock_i), .level_o(), .rise_o(aux_rise));
	wdg_sync_edge u_irc (.clock_i(clock_i), .reset_n_i(rst_n),
		.pin_i(internal_reference_clock_i), .level_o(), .rise_o(irc_rise));
	wdg_sync_edge u_osc (.clock_i(clock_i), .reset_n_i(rst_n),
		.pin_i(oscillator_clock_i), .level_o(), .rise_o(osc_rise));
	wdg_sync_edge u_ook (.clock_i(clock_i), .reset_n_i(rst_n),
		.pin_i(oscillator_ok_status_i), .level_o(osc_ok_s), .rise_o());

	// ------------------------------------------------------------
	// Period exponent lookup
	// ------------------------------------------------------------
	function automatic logic [4:0] wdg_exp(input logic fast, input logic [2:0] code);
		logic [4:0] e;
		e = fast ? WDG_EXP_FAST[code] : WDG_EXP_SLOW[code];
		return e;
	endfunction : wdg_exp

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	wdg_state_t             state_r, state_nxt;
	logic                   window_r, window_nxt;
	logic                   dbgstop_r, dbgstop_nxt;
	logic [2:0]             rate_r, rate_nxt;
	logic                   once_r, once_nxt;
	logic [1:0]             clksel_r, clksel_nxt;
	logic                   armed_r, armed_nxt;
	logic [WDG_CNT_W-1:0]   cnt_r, cnt_nxt;
	logic                   half_r, half_nxt;
	logic                   osc_ok_d_r, osc_ok_d_nxt;
	logic                   wd_reset_r, wd_reset_nxt;
	logic                   frozen_r, frozen_nxt;
	logic                   pready_r, pready_nxt;
	logic                   pslverr_r, pslverr_nxt;
	logic [31:0]            prdata_r, prdata_nxt;

	logic                   setup, access, enabled, override, win_eff, win_open;
	logic                   hit_ctrl, hit_arm, hit_clksel, hit_status;
	logic                   wr_ctrl, wr_arm, wr_clksel;
	logic                   tick, stopped, freeze, count_en, restart, fire, may_write;
	logic [4:0]             exp_cur;
	logic [7:0]             arm_data;
	logic [WDG_CNT_W-1:0]   period, last_cnt, open_at;

	// ------------------------------------------------------------
	// Decode and derived timing
	// ------------------------------------------------------------
	always_comb begin
		setup      = psel_i & ~penable_i;
		access     = psel_i & penable_i & pready_r;
		hit_ctrl   = paddr_i == WDG_ADDR_CTRL;
		hit_arm    = paddr_i == WDG_ADDR_ARM;
		hit_clksel = paddr_i == WDG_ADDR_CLKSEL;
		hit_status = paddr_i == WDG_ADDR_STATUS;
		wr_ctrl    = access & pwrite_i & hit_ctrl & (state_r == WDG_ST_RUN);
		wr_arm     = access & pwrite_i & hit_arm & (state_r == WDG_ST_RUN);
		wr_clksel  = access & pwrite_i & hit_clksel & (state_r == WDG_ST_RUN);
		arm_data   = pwdata_i[7:0];
		enabled    = rate_r != 3'h0;
		override   = enabled & background_debug_i & ~dbgstop_r & special_mode_i;
		win_eff    = window_r & ~override;
		exp_cur    = override ? WDG_EXP_MAX : wdg_exp(clksel_r[WDG_BIT_CS1], rate_r);
		exp_cur    = 5'(exp_cur - EXP_SHRINK);
		period     = {{(WDG_CNT_W-1){1'b0}}, 1'b1} << exp_cur;
		last_cnt   = WDG_CNT_W'(period - 1'b1);
		open_at    = WDG_CNT_W'(period - {2'b00, period[WDG_CNT_W-1:2]});
		win_open   = cnt_r >= open_at;
		// Fast source is aux halved, so only every second aux edge counts
		if (clksel_r[WDG_BIT_CS1])
			tick = aux_rise & half_r;
		else if (clksel_r[WDG_BIT_CS0])
			tick = osc_rise;
		else
			tick = irc_rise;
		stopped    = stop_mode_i & ~clksel_r[WDG_BIT_CS1] & ~(pseudo_stop_select_i
			& clksel_r[WDG_BIT_CS0] & osc_in_stop_enable_i);
		freeze     = background_debug_i & dbgstop_r;
		count_en   = enabled & ~stopped & ~freeze & (state_r == WDG_ST_RUN);
		may_write  = ~pwdata_i[WDG_BIT_MASK] & (special_mode_i | ~once_r);
	end

	// ------------------------------------------------------------
	// Control, arm sequence, counter and bus answer
	// ------------------------------------------------------------
	always_comb begin
		state_nxt    = state_r;
		window_nxt   = window_r;
		dbgstop_nxt  = dbgstop_r;
		rate_nxt     = rate_r;
		once_nxt     = once_r;
		clksel_nxt   = clksel_r;
		armed_nxt    = armed_r;
		cnt_nxt      = cnt_r;
		half_nxt     = aux_rise ? ~half_r : half_r;
		osc_ok_d_nxt = osc_ok_s;
		restart      = 1'b0;
		fire         = 1'b0;
		case (state_r)
			WDG_ST_LOAD: begin
				// Flash contents taken one cycle after reset release
				window_nxt  = flash_config_i[WDG_BIT_WINDOW];
				dbgstop_nxt = flash_config_i[WDG_BIT_DBGSTOP];
				rate_nxt    = flash_config_i[WDG_RATE_MSB:WDG_RATE_LSB];
				restart     = 1'b1;
				state_nxt   = WDG_ST_RUN;
			end
			WDG_ST_RUN: begin
				if (wr_ctrl) begin
					if (special_mode_i) begin
						dbgstop_nxt = pwdata_i[WDG_BIT_DBGSTOP];
						restart     = 1'b1;
					end else begin
						dbgstop_nxt = dbgstop_r | pwdata_i[WDG_BIT_DBGSTOP];
						if (!dbgstop_r && pwdata_i[WDG_BIT_DBGSTOP])
							restart = 1'b1;
					end
					if (may_write) begin
						if (!special_mode_i)
							once_nxt = 1'b1;
						if (pwdata_i[WDG_RATE_MSB:WDG_RATE_LSB] != 3'h0) begin
							rate_nxt = pwdata_i[WDG_RATE_MSB:WDG_RATE_LSB];
							restart  = 1'b1;
						end
						if (pwdata_i[WDG_BIT_WINDOW]) begin
							window_nxt = 1'b1;
							restart    = 1'b1;
						end
					end
				end
				if (wr_clksel && pwdata_i[1:0] != clksel_r) begin
					clksel_nxt = pwdata_i[1:0];
					restart    = 1'b1;
				end
				if (osc_ok_d_r && !osc_ok_s && !clksel_r[WDG_BIT_CS1]
					&& clksel_r[WDG_BIT_CS0])
					restart = 1'b1;
				if (wr_arm && enabled) begin
					if (arm_data != WDG_KEY_FIRST && arm_data != WDG_KEY_SECOND)
						fire = 1'b1;
					else if (win_eff && !win_open)
						fire = 1'b1;
					else if (arm_data == WDG_KEY_FIRST)
						armed_nxt = 1'b1;
					else if (armed_r) begin
						armed_nxt = 1'b0;
						restart   = 1'b1;
					end
				end
				if (restart)
					cnt_nxt = '0;
				else if (count_en && tick) begin
					if (cnt_r >= last_cnt)
						fire = 1'b1;
					else
						cnt_nxt = WDG_CNT_W'(cnt_r + 1'b1);
				end
				if (fire)
					state_nxt = WDG_ST_FIRE;
			end
			WDG_ST_FIRE: begin
				// Sequence state dropped so a new period starts clean
				armed_nxt = 1'b0;
				cnt_nxt   = '0;
				state_nxt = WDG_ST_RUN;
			end
			default: state_nxt = WDG_ST_LOAD;
		endcase
		wd_reset_nxt = fire;
		frozen_nxt   = freeze;
		pready_nxt   = setup;
		pslverr_nxt  = setup & ~(hit_ctrl | hit_arm | hit_clksel | hit_status);
		prdata_nxt   = 32'h0;
		// Mask bit is write-only and reads as zero; arm register reads zero
		if (setup && hit_ctrl)
			prdata_nxt = {24'h0, window_r, dbgstop_r, 3'h0, rate_r};
		else if (setup && hit_clksel)
			prdata_nxt = {30'h0, clksel_r};
		else if (setup && hit_status)
			prdata_nxt = {27'h0, once_r, freeze, win_open, enabled, armed_r};
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= WDG_ST_LOAD;
			window_r   <= 1'b0;
			dbgstop_r  <= 1'b0;
			rate_r     <= 3'h0;
			once_r     <= 1'b0;
			clksel_r   <= WDG_CLKSEL_RST;
			armed_r    <= 1'b0;
			cnt_r      <= '0;
			half_r     <= 1'b0;
			osc_ok_d_r <= 1'b0;
			wd_reset_r <= 1'b0;
			frozen_r   <= 1'b0;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			prdata_r   <= 32'h0;
		end else begin
			state_r    <= state_nxt;
			window_r   <= window_nxt;
			dbgstop_r  <= dbgstop_nxt;
			rate_r     <= rate_nxt;
			once_r     <= once_nxt;
			clksel_r   <= clksel_nxt;
			armed_r    <= armed_nxt;
			cnt_r      <= cnt_nxt;
			half_r     <= half_nxt;
			osc_ok_d_r <= osc_ok_d_nxt;
			wd_reset_r <= wd_reset_nxt;
			frozen_r   <= frozen_nxt;
			pready_r   <= pready_nxt;
			pslverr_r  <= pslverr_nxt;
			prdata_r   <= prdata_nxt;
		end
	end

	assign watchdog_reset_o  = wd_reset_r;
	assign counters_frozen_o = frozen_r;
	assign pready_o          = pready_r;
	assign pslverr_o         = pslverr_r;
	assign prdata_o          = prdata_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n);

	chk_reset_single_pulse: assert property (wd_reset_r |=> !wd_reset_r && cnt_r == '0
		&& !armed_r) else $error("watchdog reset not a single pulse");
	chk_bad_key_fires: assert property (wr_arm && enabled && arm_data != WDG_KEY_FIRST
		&& arm_data != WDG_KEY_SECOND |=> wd_reset_r)
		else $error("bad arm value did not reset");
	chk_disabled_quiet: assert property (state_r == WDG_ST_RUN && rate_r == 3'h0
		|=> !wd_reset_r) else $error("reset while disabled");
	chk_window_early: assert property (wr_arm && enabled && win_eff && !win_open
		|=> wd_reset_r) else $error("early arm in window mode missed");
	chk_key_restart: assert property (wr_arm && enabled && armed_r
		&& arm_data == WDG_KEY_SECOND |=> cnt_r == '0 && !armed_r)
		else $error("second key did not restart");
	chk_mask_holds: assert property (wr_ctrl && pwdata_i[WDG_BIT_MASK]
		|=> $stable(rate_r) && $stable(window_r) && $stable(once_r))
		else $error("masked write changed fields");
	chk_once_normal: assert property (wr_ctrl && once_r && !special_mode_i
		|=> $stable(rate_r) && $stable(window_r))
		else $error("second normal write took effect");
	chk_dbgstop_sticky: assert property (wr_ctrl && !special_mode_i && dbgstop_r
		|=> dbgstop_r) else $error("debug stop cleared in normal mode");
	chk_special_restart: assert property (wr_ctrl && special_mode_i && !fire
		|=> cnt_r == '0) else $error("special write did not restart");
	chk_freeze_holds: assert property (state_r == WDG_ST_RUN && freeze && !restart
		&& !fire |=> $stable(cnt_r)) else $error("counter moved while frozen");
	chk_expire_fires: assert property (count_en && tick && !restart
		&& cnt_r >= last_cnt |=> wd_reset_r ##1 !wd_reset_r)
		else $error("expiry did not reset");

	cov_expire: cover property (count_en && tick && cnt_r >= last_cnt);
	cov_key_pair: cover property (wr_arm && arm_data == WDG_KEY_FIRST
		##[1:40] wr_arm && arm_data == WDG_KEY_SECOND);
	cov_window_arm: cover property (wr_arm && win_eff && win_open);
	cov_override: cover property (override && window_r);

endmodule : wdg_control

// ==== core/wdg_pkg.sv ====
// Package: constants and types of the watchdog control block
package wdg_pkg;

	// ------------------------------------------------------------
	// Register map (index = printed offset, byte address = 4 x index)
	// ------------------------------------------------------------
	localparam int          WDG_AW          = 12;
	localparam logic [11:0] WDG_IDX_CTRL    = 12'h00c;
	localparam logic [11:0] WDG_IDX_ARM     = 12'h00f;
	localparam logic [11:0] WDG_IDX_CLKSEL  = 12'h020;
	localparam logic [11:0] WDG_IDX_STATUS  = 12'h021;
	localparam logic [11:0] WDG_ADDR_CTRL   = {WDG_IDX_CTRL[9:0], 2'b00};
	localparam logic [11:0] WDG_ADDR_ARM    = {WDG_IDX_ARM[9:0], 2'b00};
	localparam logic [11:0] WDG_ADDR_CLKSEL = {WDG_IDX_CLKSEL[9:0], 2'b00};
	localparam logic [11:0] WDG_ADDR_STATUS = {WDG_IDX_STATUS[9:0], 2'b00};

	// ------------------------------------------------------------
	// Control and clock-select register fields
	// ------------------------------------------------------------
	localparam int WDG_BIT_WINDOW  = 7;
	localparam int WDG_BIT_DBGSTOP = 6;
	localparam int WDG_BIT_MASK    = 5;
	localparam int WDG_RATE_MSB    = 2;
	localparam int WDG_RATE_LSB    = 0;
	localparam int WDG_BIT_CS0     = 0;
	localparam int WDG_BIT_CS1     = 1;

	// ------------------------------------------------------------
	// Reset values, keys and timing
	// ------------------------------------------------------------
	localparam logic [1:0] WDG_CLKSEL_RST = 2'h0;
	localparam logic [7:0] WDG_KEY_FIRST  = 8'h55;
	localparam logic [7:0] WDG_KEY_SECOND = 8'haa;
	localparam logic [4:0] WDG_EXP_MAX    = 5'h18;
	localparam int         WDG_CNT_W      = 25;

	// Exponents for rate codes 1..7, index 0 unused (disabled)
	localparam logic [4:0] WDG_EXP_SLOW [8] = '{5'h00, 5'h0e, 5'h10, 5'h12,
		5'h14, 5'h16, 5'h17, 5'h18};
	localparam logic [4:0] WDG_EXP_FAST [8] = '{5'h00, 5'h07, 5'h09, 5'h0b,
		5'h0d, 5'h0f, 5'h10, 5'h11};

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		WDG_ST_LOAD = 2'b00,
		WDG_ST_RUN  = 2'b01,
		WDG_ST_FIRE = 2'b11
	} wdg_state_t;

endpackage : wdg_pkg

// ==== core/wdg_sync_edge.sv ====
// Two-flop synchroniser with rising-edge pulse for one asynchronous pin
`timescale 1ns/100ps
module wdg_sync_edge (
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o
);

	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;
	logic last_r;
	logic last_nxt;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		meta_nxt = pin_i;
		sync_nxt = meta_r;
		last_nxt = sync_r;
	end

	// Only the second flop feeds the edge detector
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			last_r <= last_nxt;
		end
	end

	assign level_o = sync_r;
	assign rise_o  = sync_r & ~last_r;

endmodule : wdg_sync_edge

// ==== tb/tb_watchdog_control.sv ====
// Testbench: self-checking run of the watchdog control block
`timescale 1ns/100ps
module tb_watchdog_control;
	import wdg_pkg::*;

	// ------------------------------------------------------------
	// Settings and signals
	// ------------------------------------------------------------
	// Shrink keeps slow code 1 at 2^8 ticks; must stay below fast exponent 7
	localparam logic [4:0] SHRINK = 5'h06;
	localparam int         TICK   = 6;
	localparam int         PERIOD = 256 * TICK;
	localparam int         LIMIT  = 40000;

	typedef struct {
		logic [31:0] data;
		logic        err;
		logic        rd;
	} wdg_note_t;

	logic        clock_i;
	logic        reset_n_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        aux_clock_i;
	logic        internal_reference_clock_i;
	logic        oscillator_clock_i;
	logic        oscillator_ok_status_i;
	logic        special_mode_i;
	logic        stop_mode_i;
	logic        pseudo_stop_select_i;
	logic        osc_in_stop_enable_i;
	logic        background_debug_i;
	logic [7:0]  flash_config_i;
	logic        watchdog_reset_o;
	logic        counters_frozen_o;
	logic [7:0]  bad;
	int          failures   = 0;
	int          num_checks = 0;
	int          rst_cnt    = 0;
	int          cyc        = 0;
	int          seed       = 6080;
	wdg_note_t   note;
	wdg_note_t   sb_q[$];

	wdg_control #(.EXP_SHRINK(SHRINK)) i_wdg_control (
		.clock_i                   (clock_i),
		.reset_n_i                 (reset_n_i),
		.psel_i                    (psel_i),
		.penable_i                 (penable_i),
		.pwrite_i                  (pwrite_i),
		.paddr_i                   (paddr_i),
		.pwdata_i                  (pwdata_i),
		.prdata_o                  (prdata_o),
		.pready_o                  (pready_o),
		.pslverr_o                 (pslverr_o),
		.aux_clock_i               (aux_clock_i),
		.internal_reference_clock_i(internal_reference_clock_i),
		.oscillator_clock_i        (oscillator_clock_i),
		.oscillator_ok_status_i    (oscillator_ok_status_i),
		.special_mode_i            (special_mode_i),
		.stop_mode_i               (stop_mode_i),
		.pseudo_stop_select_i      (pseudo_stop_select_i),
		.osc_in_stop_enable_i      (osc_in_stop_enable_i),
		.background_debug_i        (background_debug_i),
		.flash_config_i            (flash_config_i),
		.watchdog_reset_o          (watchdog_reset_o),
		.counters_frozen_o         (counters_frozen_o)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// No fixed latency assumed: wait on pready, bounded
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic [31:0] e, input logic er);
		int n;
		sb_q.push_back('{e, er, !w});
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50)
			chk("pready", 32'h1, 32'h0);
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		// Idle edge keeps the next setup from reassigning psel in this step
		@(posedge clock_i);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(a, 1'b1, {24'h0, d}, 32'h0, 1'b0);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(a, 1'b0, 32'h0, {24'h0, e}, 1'b0);
	endtask : rd

	task automatic arm(input logic [7:0] v);
		wr(WDG_ADDR_ARM, v);
	endtask : arm

	task automatic watch(input int cycles, input int exp_new);
		int base;
		base = rst_cnt;
		repeat (cycles) @(posedge clock_i);
		chk("reset pulses", 32'(exp_new), 32'(rst_cnt - base));
	endtask : watch

	task automatic do_reset(input logic [7:0] f, input logic sp);
		reset_n_i      <= 1'b0;
		flash_config_i <= f;
		special_mode_i <= sp;
		repeat (16) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
	endtask : do_reset

	// ------------------------------------------------------------
	// Clocks, source pins, monitor and timeout
	// ------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	// Sources stay well under a quarter of the system rate
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc % 3 == 0) internal_reference_clock_i <= ~internal_reference_clock_i;
		if (cyc % 4 == 0) oscillator_clock_i <= ~oscillator_clock_i;
		if (cyc % 5 == 0) aux_clock_i <= ~aux_clock_i;
		if (watchdog_reset_o === 1'b1) rst_cnt <= rst_cnt + 1;
		if (pready_o === 1'b1) begin
			if (sb_q.size() == 0) chk("spare answer", 32'h0, 32'h1);
			else begin
				note = sb_q.pop_front();
				chk("pslverr", {31'h0, note.err}, {31'h0, pslverr_o});
				if (note.rd) chk("prdata", note.data, prdata_o);
			end
		end
		if (cyc == LIMIT) begin
			failures = failures + 1;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		reset_n_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
		paddr_i = 12'h000; pwdata_i = 32'h0; aux_clock_i = 1'b0;
		internal_reference_clock_i = 1'b0; oscillator_clock_i = 1'b0;
		oscillator_ok_status_i = 1'b1; special_mode_i = 1'b0; stop_mode_i = 1'b0;
		pseudo_stop_select_i = 1'b0; osc_in_stop_enable_i = 1'b0;
		background_debug_i = 1'b0; flash_config_i = 8'h00;
		do_reset(8'h01, 1'b0);
		rd(WDG_ADDR_CTRL, 8'h01);
		watch(PERIOD - 150, 0);
		watch(300, 1);
		watch(1000, 0);
		arm(8'h55); arm(8'h55); arm(8'haa);
		watch(1000, 0);
		stop_mode_i <= 1'b1;
		watch(2000, 0);
		stop_mode_i <= 1'b0;
		do bad = 8'($random(seed)); while (bad == WDG_KEY_FIRST || bad == WDG_KEY_SECOND);
		arm(bad);
		watch(4, 1);
		wr(WDG_ADDR_CTRL, 8'h22);
		rd(WDG_ADDR_CTRL, 8'h01);
		wr(WDG_ADDR_CTRL, 8'h07);
		rd(WDG_ADDR_CTRL, 8'h07);
		wr(WDG_ADDR_CTRL, 8'h03);
		rd(WDG_ADDR_CTRL, 8'h07);
		wr(WDG_ADDR_CTRL, 8'h60);
		rd(WDG_ADDR_CTRL, 8'h47);
		wr(WDG_ADDR_CTRL, 8'h20);
		rd(WDG_ADDR_CTRL, 8'h47);
		background_debug_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		chk("frozen", 32'h1, {31'h0, counters_frozen_o});
		background_debug_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		chk("frozen", 32'h0, {31'h0, counters_frozen_o});
		wr(WDG_ADDR_CLKSEL, 8'h02);
		rd(WDG_ADDR_CLKSEL, 8'h02);
		wr(WDG_ADDR_CLKSEL, 8'h01);
		rd(WDG_ADDR_CLKSEL, 8'h01);
		wr(WDG_ADDR_CLKSEL, 8'h00);
		apb(12'h100, 1'b1, 32'h0, 32'h0, 1'b1);
		apb(12'h100, 1'b0, 32'h0, 32'h0, 1'b1);
		// Disabled watchdog: arm writes and zero writes
		do_reset(8'h00, 1'b0);
		arm(8'h12);
		watch(10, 0);
		wr(WDG_ADDR_CTRL, 8'h00);
		wr(WDG_ADDR_CTRL, 8'h02);
		rd(WDG_ADDR_CTRL, 8'h00);
		// Window mode
		do_reset(8'h81, 1'b0);
		watch(100, 0);
		arm(8'h55);
		watch(5, 1);
		watch(1300, 0);
		arm(8'h55); arm(8'haa);
		watch(1300, 0);
		watch(400, 1);
		// Special mode
		do_reset(8'h01, 1'b1);
		repeat (3) begin
			watch(PERIOD - 500, 0);
			wr(WDG_ADDR_CTRL, 8'h21);
		end
		wr(WDG_ADDR_CTRL, 8'h05);
		rd(WDG_ADDR_CTRL, 8'h05);
		wr(WDG_ADDR_CTRL, 8'h06);
		rd(WDG_ADDR_CTRL, 8'h06);
		wr(WDG_ADDR_CTRL, 8'h40);
		rd(WDG_ADDR_CTRL, 8'h46);
		wr(WDG_ADDR_CTRL, 8'h00);
		rd(WDG_ADDR_CTRL, 8'h06);
		// Debug override: early key accepted, period far beyond code 1
		wr(WDG_ADDR_CTRL, 8'h81);
		background_debug_i <= 1'b1;
		arm(8'h55);
		watch(2000, 0);
		wr(WDG_ADDR_CTRL, 8'h21);
		background_debug_i <= 1'b0;
		// Oscillator source keeps running in pseudo stop
		wr(WDG_ADDR_CLKSEL, 8'h01);
		stop_mode_i          <= 1'b1;
		pseudo_stop_select_i <= 1'b1;
		osc_in_stop_enable_i <= 1'b1;
		watch(2300, 1);
		stop_mode_i <= 1'b0;
		watch(1500, 0);
		oscillator_ok_status_i <= 1'b0;
		watch(1500, 0);
		oscillator_ok_status_i <= 1'b1;
		// Halved aux source keeps running in full stop
		wr(WDG_ADDR_CTRL, 8'h03);
		wr(WDG_ADDR_CLKSEL, 8'h02);
		stop_mode_i          <= 1'b1;
		pseudo_stop_select_i <= 1'b0;
		watch(1000, 1);
		stop_mode_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		chk("open notes", 32'h0, 32'(sb_q.size()));
		summarize();
	end

endmodule : tb_watchdog_control
